// ===== src/rx_store.sv
// module: 4096-byte receive character store
`timescale 1ns/1ps
module rx_store (
	// clock
	input wire logic clk,
	input wire logic ce,
	// port
	rx_store_if.store bus
);
	logic [7:0] mem [serial_blk_pkg::RX_DEPTH];
	logic [7:0] rd_q;

	always_ff @(posedge clk) begin
		if (ce) begin
			if (bus.wr_en) begin
				mem[bus.wr_addr] <= bus.wr_data;
			end
			rd_q <= mem[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_q;
endmodule

// ===== src/rx_store_if.sv
// interface: receive buffer read and write port
`timescale 1ns/1ps
interface rx_store_if;
	logic wr_en;
	logic [11:0] wr_addr;
	logic [7:0] wr_data;
	logic [11:0] rd_addr;
	logic [7:0] rd_data;
	modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ===== src/serial_blk_pkg.sv
// package: block codes, image layout, sizes and timing counts
package serial_blk_pkg;
	// ---------------------------------------------------------------
	// block identifiers
	// ---------------------------------------------------------------
	localparam logic [7:0] DATA_ID_MAX = 8'h7F;
	localparam logic [7:0] WARM_ID = 8'hFE;
	localparam logic [7:0] COLD_ID = 8'hFF;
	// ---------------------------------------------------------------
	// image layout
	// ---------------------------------------------------------------
	localparam int IN_BYTES = 14;
	localparam int OUT_BYTES = 10;
	localparam int RD_BLOCK_BYTES = 16;
	localparam int RD_DATA_BYTES = 14;
	localparam int WR_DATA_BYTES = 9;
	localparam int SEQ_OFS = 0;
	localparam int LEN_OFS = 1;
	localparam int DATA_OFS = 2;
	localparam logic [7:0] LEN_CONT = 8'hFF;
	localparam logic [7:0] LEN_STAT_A = 8'hFC;
	localparam logic [7:0] LEN_STAT_B = 8'hFD;
	localparam logic [7:0] SEQ_RESET = 8'h00;
	// ---------------------------------------------------------------
	// buffer and power-up
	// ---------------------------------------------------------------
	localparam int RX_DEPTH = 4096;
	localparam int RX_AW = 12;
	localparam int CLEAR_CYCLES = 4096;
endpackage

// ===== src/serial_blk_xfer.sv
// top: serial block transfer between link and processor images
`timescale 1ns/1ps
module serial_blk_xfer (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	// processor side
	input wire logic SCAN_I,
	input wire logic [127:0] RD_IMAGE_UNUSED_I,
	output logic [127:0] RD_IMAGE_O,
	input wire logic [79:0] WR_IMAGE_I,
	input wire logic WR_STROBE_I,
	input wire logic RUN_MODE_I,
	input wire logic PROGRAM_MODE_I,
	// configuration
	input wire logic CFG_DONE_I,
	input wire logic NV_SWAP_I,
	input wire logic NV_STOP_ON_IDLE_I,
	input wire logic [7:0] STATUS_LEN_I,
	input wire logic [111:0] STATUS_DATA_I,
	// serial receive side
	input wire logic RX_VALID_I,
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_TERM_I,
	// serial transmit side
	output logic TX_VALID_O,
	output logic [7:0] TX_DATA_O,
	input wire logic TX_READY_I,
	// status
	output logic READY_O,
	output logic WARM_O,
	output logic COLD_O
);
	typedef enum {S_CLEAR, S_WAIT_CFG, S_RUN} mode_e;
	typedef enum {R_IDLE, R_FETCH, R_WAIT, R_LOAD} rd_e;

	rx_store_if sbus ();
	rx_store u_store (.clk(REF_CLK_I), .ce(CE_I), .bus(sbus));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic is_data_id(input logic [7:0] id);
		return id <= serial_blk_pkg::DATA_ID_MAX;
	endfunction

	function automatic logic [111:0] pair_swap(input logic [111:0] v);
		logic [111:0] r;
		r = '0;
		for (int k = 0; k < 7; k++) begin
			r[k*16 +: 8] = v[k*16+8 +: 8];
			r[k*16+8 +: 8] = v[k*16 +: 8];
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// input pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] run_s1_q, run_s2_q;
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			run_s1_q <= 2'h0;
			run_s2_q <= 2'h0;
		end else if (CE_I) begin
			run_s1_q <= {PROGRAM_MODE_I, RUN_MODE_I};
			run_s2_q <= run_s1_q;
		end
	end
	logic running;
	assign running = run_s2_q[0] && !run_s2_q[1];

	// ---------------------------------------------------------------
	// power-up sequencing
	// ---------------------------------------------------------------
	mode_e mode_q, mode_d;
	logic [12:0] clr_q, clr_d;
	logic swap_q, swap_d, stop_q, stop_d;
	logic warm_q, warm_d, cold_q, cold_d;
	logic [7:0] wr_id;
	assign wr_id = WR_IMAGE_I[7:0];

	always_comb begin
		mode_d = mode_q;
		clr_d = clr_q;
		swap_d = swap_q;
		stop_d = stop_q;
		warm_d = 1'b0;
		cold_d = 1'b0;
		case (mode_q)
			S_CLEAR: begin
				clr_d = clr_q + 13'h1;
				if (clr_q == 13'(serial_blk_pkg::CLEAR_CYCLES - 1)) begin
					swap_d = NV_SWAP_I;
					stop_d = NV_STOP_ON_IDLE_I;
					mode_d = S_WAIT_CFG;
				end
			end
			S_WAIT_CFG: begin
				if (CFG_DONE_I) begin
					mode_d = S_RUN;
				end
			end
			default: begin
			end
		endcase
		if (WR_STROBE_I && mode_q != S_CLEAR) begin
			if (wr_id == serial_blk_pkg::WARM_ID) begin
				warm_d = 1'b1;
				mode_d = S_WAIT_CFG;
			end else if (wr_id == serial_blk_pkg::COLD_ID) begin
				cold_d = 1'b1;
				mode_d = S_CLEAR;
				clr_d = 13'h0;
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			mode_q <= S_CLEAR;
			clr_q <= 13'h0;
			swap_q <= 1'b0;
			stop_q <= 1'b0;
			warm_q <= 1'b0;
			cold_q <= 1'b0;
		end else if (CE_I) begin
			mode_q <= mode_d;
			clr_q <= clr_d;
			swap_q <= swap_d;
			stop_q <= stop_d;
			warm_q <= warm_d;
			cold_q <= cold_d;
		end
	end

	logic active;
	assign active = (mode_q == S_RUN) && (running || !stop_q);

	// ---------------------------------------------------------------
	// receive buffering
	// ---------------------------------------------------------------
	logic [12:0] wcnt_q, wcnt_d;
	logic [12:0] msg_q, msg_d;
	logic [12:0] rpos_q, rpos_d;
	logic pend_q, pend_d;
	logic rx_take;
	assign rx_take = active && RX_VALID_I && !pend_q && wcnt_q < 13'(serial_blk_pkg::RX_DEPTH);

	always_comb begin
		sbus.wr_en = rx_take && mode_q != S_CLEAR;
		sbus.wr_addr = wcnt_q[11:0];
		sbus.wr_data = RX_DATA_I;
		if (mode_q == S_CLEAR) begin
			sbus.wr_en = 1'b1;
			sbus.wr_addr = clr_q[11:0];
			sbus.wr_data = 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// read block builder
	// ---------------------------------------------------------------
	rd_e rs_q, rs_d;
	logic [3:0] idx_q, idx_d;
	logic [3:0] cnt_q, cnt_d;
	logic [111:0] dat_q, dat_d;
	logic [7:0] seq_q, seq_d;
	logic [7:0] len_q, len_d;
	logic [111:0] img_q, img_d;
	logic [12:0] left;
	assign left = msg_q - rpos_q;
	assign sbus.rd_addr = rpos_q[11:0];

	always_comb begin
		rs_d = rs_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		dat_d = dat_q;
		seq_d = seq_q;
		len_d = len_q;
		img_d = img_q;
		wcnt_d = wcnt_q + 13'(rx_take);
		msg_d = msg_q;
		rpos_d = rpos_q;
		pend_d = pend_q;
		if (active && !pend_q && RX_TERM_I && wcnt_d != 13'h0) begin
			pend_d = 1'b1;
			msg_d = wcnt_d;
			rpos_d = 13'h0;
		end
		case (rs_q)
			R_IDLE: begin
				if (SCAN_I && mode_q == S_RUN) begin
					if (pend_q) begin
						cnt_d = (left > 13'(serial_blk_pkg::RD_DATA_BYTES)) ?
							4'(serial_blk_pkg::RD_DATA_BYTES) : 4'(left);
						idx_d = 4'h0;
						dat_d = '0;
						rs_d = R_FETCH;
					end else begin
						len_d = STATUS_LEN_I[0] ? serial_blk_pkg::LEN_STAT_B :
							serial_blk_pkg::LEN_STAT_A;
						img_d = STATUS_DATA_I;
						seq_d = seq_q + 8'h01;
					end
				end
			end
			R_FETCH: begin
				rs_d = R_WAIT;
			end
			R_WAIT: begin
				dat_d[idx_q*8 +: 8] = sbus.rd_data;
				idx_d = idx_q + 4'h1;
				rpos_d = rpos_q + 13'h1;
				rs_d = (idx_q + 4'h1 == cnt_q) ? R_LOAD : R_FETCH;
			end
			R_LOAD: begin
				img_d = swap_q ? pair_swap(dat_q) : dat_q;
				if (left > 13'h0) begin
					len_d = serial_blk_pkg::LEN_CONT;
				end else begin
					len_d = {4'h0, cnt_q};
					pend_d = 1'b0;
					wcnt_d = 13'h0;
				end
				seq_d = seq_q + 8'h01;
				rs_d = R_IDLE;
			end
			default: rs_d = R_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			rs_q <= R_IDLE;
			idx_q <= 4'h0;
			cnt_q <= 4'h0;
			dat_q <= '0;
			seq_q <= serial_blk_pkg::SEQ_RESET;
			len_q <= 8'h00;
			img_q <= '0;
			wcnt_q <= 13'h0;
			msg_q <= 13'h0;
			rpos_q <= 13'h0;
			pend_q <= 1'b0;
		end else if (CE_I) begin
			rs_q <= rs_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			dat_q <= dat_d;
			seq_q <= seq_d;
			len_q <= len_d;
			img_q <= img_d;
			wcnt_q <= wcnt_d;
			msg_q <= msg_d;
			rpos_q <= rpos_d;
			pend_q <= pend_d;
		end
	end

	assign RD_IMAGE_O = {img_q, len_q, seq_q};

	// ---------------------------------------------------------------
	// write block transmitter
	// ---------------------------------------------------------------
	logic [71:0] tx_buf_q, tx_buf_d;
	logic [3:0] tx_left_q, tx_left_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic tx_v_q, tx_v_d;

	always_comb begin
		tx_buf_d = tx_buf_q;
		tx_left_d = tx_left_q;
		tx_data_d = tx_data_q;
		tx_v_d = tx_v_q;
		if (tx_v_q && TX_READY_I) begin
			tx_v_d = 1'b0;
		end
		if (!tx_v_d && tx_left_q != 4'h0 && active) begin
			tx_data_d = tx_buf_q[7:0];
			tx_buf_d = {8'h00, tx_buf_q[71:8]};
			tx_left_d = tx_left_q - 4'h1;
			tx_v_d = 1'b1;
		end
		if (WR_STROBE_I && tx_left_q == 4'h0 && active && is_data_id(wr_id)) begin
			tx_buf_d = WR_IMAGE_I[79:8];
			tx_left_d = 4'(serial_blk_pkg::WR_DATA_BYTES);
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			tx_buf_q <= '0;
			tx_left_q <= 4'h0;
			tx_data_q <= 8'h00;
			tx_v_q <= 1'b0;
		end else if (CE_I) begin
			tx_buf_q <= tx_buf_d;
			tx_left_q <= tx_left_d;
			tx_data_q <= tx_data_d;
			tx_v_q <= tx_v_d;
		end
	end

	assign TX_VALID_O = tx_v_q;
	assign TX_DATA_O = tx_data_q;
	assign READY_O = mode_q == S_RUN;
	assign WARM_O = warm_q;
	assign COLD_O = cold_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_load;
		rs_q == R_LOAD && CE_I;
	endsequence

	a_seq_bumps: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		s_load |=> seq_q == $past(seq_q) + 8'h01)
		else $error("sequence not bumped");
	a_len_cont: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		s_load and left > 13'h0 |=> len_q == 8'hFF && $past(cnt_q) == 4'hE)
		else $error("continuation block wrong");
	a_len_final: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		s_load and left == 13'h0 |=> len_q == {4'h0, $past(cnt_q)} && !pend_q)
		else $error("final length wrong");
	a_len_range: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		len_q <= 8'h0E || len_q >= 8'hFC)
		else $error("bad length byte");
	a_stat_code: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		rs_q == R_IDLE && SCAN_I && CE_I && mode_q == S_RUN && !pend_q
		|=> len_q == 8'hFC || len_q == 8'hFD)
		else $error("status code missing");
	a_no_early: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		mode_q != S_RUN |-> !rx_take && !(tx_v_d && (!tx_v_q || TX_READY_I)))
		else $error("serial active before config");
	a_cold_boot: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		CE_I && WR_STROBE_I && wr_id == 8'hFF && mode_q != S_CLEAR
		|=> mode_q == S_CLEAR && cold_q)
		else $error("cold restart ignored");
	a_hold_rx: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		pend_q |-> !rx_take)
		else $error("rx accepted during transfer");
	a_reserved: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		CE_I && WR_STROBE_I && wr_id[7] && wr_id < 8'hFE && tx_left_q == 4'h0 && !tx_v_q
		|=> tx_left_q == 4'h0)
		else $error("reserved id acted on");
endmodule

// ===== test/proc_model.sv
// processor model: periodic scans, consume read blocks on sequence change
`timescale 1ns/1ps
module proc_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [127:0] rd_image,
	output logic scan
);
	// ---------------------------------------------------------------
	// scan pacing and block capture
	// ---------------------------------------------------------------
	logic [7:0] last_seq;
	int gap;
	int msgs_done;
	logic [127:0] blocks[$];
	always @(posedge clk) begin
		scan <= 1'b0;
		if (rst) begin
			gap <= 0;
			msgs_done <= 0;
			last_seq <= rd_image[7:0];
		end else begin
			gap <= gap + 1;
			if (en && gap >= 40) begin
				scan <= 1'b1;
				gap <= 0;
			end
			if (rd_image[7:0] !== last_seq) begin
				blocks.push_back(rd_image);
				last_seq <= rd_image[7:0];
				if (rd_image[15:8] <= 8'h0E) begin
					msgs_done <= msgs_done + 1;
				end
			end
		end
	end
endmodule

// ===== test/tb_top.sv
// testbench: block ids, serial send, read blocks, sequence wrap, restarts
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scan, txv, wrm, cld, rdy;
	logic wr_stb = 1'b0;
	logic cfg = 1'b0;
	logic program_mode = 1'b0;
	logic rxv = 1'b0;
	logic term = 1'b0;
	logic en = 1'b0;
	logic [79:0] wimg = '0;
	logic [7:0] rxd = 8'h00;
	logic [7:0] slen = 8'h00;
	logic [7:0] txd;
	logic swp = 1'b0;
	logic stop_cfg = 1'b1;
	int base = 0;
	logic [111:0] sdat = {14{8'h5A}};
	logic [127:0] rd;
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;
	typedef struct {logic [7:0] id; logic sent;} wr_row_s;
	wr_row_s rows[4] = '{'{8'h00, 1'b1}, '{8'h7F, 1'b1}, '{8'h80, 1'b0}, '{8'hFD, 1'b0}};

	serial_blk_xfer i_dut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .SCAN_I(scan),
		.RD_IMAGE_UNUSED_I(128'h0), .RD_IMAGE_O(rd), .WR_IMAGE_I(wimg), .WR_STROBE_I(wr_stb),
		.RUN_MODE_I(1'b1), .PROGRAM_MODE_I(program_mode), .CFG_DONE_I(cfg), .NV_SWAP_I(swp),
		.NV_STOP_ON_IDLE_I(stop_cfg), .STATUS_LEN_I(slen), .STATUS_DATA_I(sdat),
		.RX_VALID_I(rxv), .RX_DATA_I(rxd), .RX_TERM_I(term), .TX_VALID_O(txv),
		.TX_DATA_O(txd), .TX_READY_I(1'b1), .READY_O(rdy), .WARM_O(wrm), .COLD_O(cld));
	proc_model i_proc (.clk(clk), .rst(rst), .en(en), .rd_image(rd), .scan(scan));

	// ---------------------------------------------------------------
	// clock, timeout, helpers
	// ---------------------------------------------------------------
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (s !== 1'b1 && n < lim);
	endtask
	task send(input logic [7:0] id);
		@(posedge clk);
		wimg <= {72'h090807060504030201, id};
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task tx9;
		for (int k = 0; k < 9; k++) begin
			wait_hi(txv, 50);
			chk(txd, 8'(k + 1));
		end
	endtask
	task rx_msg(input logic [7:0] first, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rxv <= 1'b1;
			rxd <= first + 8'(i);
		end
		@(posedge clk);
		rxv <= 1'b0;
		term <= 1'b1;
		@(posedge clk);
		term <= 1'b0;
	endtask
	task wait_blocks(input int n);
		int k;
		k = 0;
		while (i_proc.blocks.size() < n && k < 12000) begin
			@(posedge clk);
			k++;
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk({7'h0, txv}, 8'h00);
		chk(rd[7:0], serial_blk_pkg::SEQ_RESET);
		repeat (4200) @(posedge clk);
		chk({7'h0, rdy}, 8'h00);
		cfg <= 1'b1;
		@(posedge clk);
		cfg <= 1'b0;
		repeat (20) @(posedge clk);
		chk({7'h0, rdy}, 8'h01);
		foreach (rows[r]) begin
			send(rows[r].id);
			if (rows[r].sent) begin
				tx9();
			end else begin
				repeat (30) @(posedge clk);
				chk({7'h0, txv}, 8'h00);
			end
		end
		program_mode <= 1'b1;
		repeat (5) @(posedge clk);
		send(8'h00);
		repeat (30) @(posedge clk);
		chk({7'h0, txv}, 8'h00);
		program_mode <= 1'b0;
		repeat (5) @(posedge clk);
		send(8'h00);
		tx9();
		rx_msg(8'h30, 20);
		en <= 1'b1;
		wait_blocks(250);
		slen <= 8'h01;
		wait_blocks(258);
		en <= 1'b0;
		chk(i_proc.blocks[0][15:8], 8'hFF);
		for (int j = 0; j < 14; j++) chk(i_proc.blocks[0][16+8*j +: 8], 8'h30 + 8'(j));
		chk(i_proc.blocks[1][15:8], 8'h06);
		for (int j = 0; j < 6; j++) chk(i_proc.blocks[1][16+8*j +: 8], 8'h3E + 8'(j));
		chk(i_proc.msgs_done[7:0], 8'h01);
		chk(i_proc.blocks[2][15:8], 8'hFC);
		chk(i_proc.blocks[2][23:16], 8'h5A);
		chk(i_proc.blocks[257][15:8], 8'hFD);
		for (int k = 0; k < 258; k++) chk(i_proc.blocks[k][7:0], 8'(k + 1));
		send(8'hFE);
		wait_hi(wrm, 20);
		chk({7'h0, wrm}, 8'h01);
		repeat (5) @(posedge clk);
		chk({7'h0, rdy}, 8'h00);
		stop_cfg <= 1'b0;
		swp <= 1'b1;
		send(8'hFF);
		wait_hi(cld, 20);
		chk({7'h0, cld}, 8'h01);
		repeat (4200) @(posedge clk);
		cfg <= 1'b1;
		program_mode <= 1'b1;
		@(posedge clk);
		cfg <= 1'b0;
		repeat (5) @(posedge clk);
		chk({7'h0, rdy}, 8'h01);
		send(8'h00);
		tx9();
		rx_msg(8'hA0, 4);
		base = i_proc.blocks.size();
		en <= 1'b1;
		wait_blocks(base + 1);
		en <= 1'b0;
		chk(i_proc.blocks[base][15:8], 8'h04);
		chk(i_proc.blocks[base][23:16], 8'hA1);
		chk(i_proc.blocks[base][31:24], 8'hA0);
		chk(i_proc.blocks[base][39:32], 8'hA3);
		chk(i_proc.blocks[base][47:40], 8'hA2);
		wrap_up();
	end
endmodule
